/* File: bench/fault_sink.sv */
// Purpose: reset controller stand-in that counts fault requests
// Assumes: requests are levels in the pclk domain
// Notes: counts rising edges only
module fault_sink (
  input wire logic pclk, // Clock
  input wire logic proc_req, // Processor reset request
  input wire logic all_req, // All resets request
  output int n_proc, // Processor requests seen
  output int n_all // All-reset requests seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic p_r = 0;
  logic a_r = 0;
  initial n_proc = 0;
  initial n_all = 0;
  always @(posedge pclk) begin
    if (proc_req && !p_r) n_proc++;
    if (all_req && !a_r) n_all++;
    p_r = proc_req;
    a_r = all_req;
  end
endmodule // fault_sink

/* File: bench/test_windowed_watchdog_timer.sv */
// Purpose: self-checking bench for the windowed watchdog
// Assumes: slow clock enable held high, one tick per pclk
// Notes: underflow timing is measured in pclk cycles
module test_windowed_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se, slow_clk_en = 1, debug_state = 0, idle_state = 0;
  logic [11:0] paddr = 0;
  word_type pwdata = 0, prdata, rd;
  logic pready, pslverr, wdt_irq, wdt_fault, fault_proc_reset, fault_all_reset;
  int fails = 0, n_tests = 0, cyc = 0, n, n_proc, n_all;
  always #12.5 pclk = ~pclk;
  windowed_watchdog_timer windowed_watchdog_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_clk_en(slow_clk_en), .debug_state(debug_state), .idle_state(idle_state),
    .wdt_irq(wdt_irq), .wdt_fault(wdt_fault), .fault_proc_reset(fault_proc_reset), .fault_all_reset(fault_all_reset));
  fault_sink fault_sink_inst (.pclk(pclk), .proc_req(fault_proc_reset), .all_req(fault_all_reset),
    .n_proc(n_proc), .n_all(n_all));
  task automatic chk(input word_type s, input word_type e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input word_type d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; se = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  // Cycles until the interrupt shows, compared with a model count
  task automatic irq_after(input int e);
    n = 0;
    while (wdt_irq !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk(word_type'(n > e - 12 && n < e + 12), 1);
  endtask
  task report_and_stop;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop;
    end
  end
  initial begin
    n = $urandom(32'hAEE77DDB);
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h004, 0); chk(rd, 32'h3FFF_2FFF);
    apb(0, 12'h008, 0); chk(rd, 0);
    apb(0, 12'h020, 0); chk(se, 1);
    apb(1, 12'h004, 32'h1002_7004);
    apb(1, 12'h004, 32'h0000_0FFF);
    apb(0, 12'h004, 0); chk(rd, 32'h1002_7004);
    apb(1, 12'h000, {8'hA5 ^ 8'($urandom_range(1, 255)), 24'h00_0001});
    apb(0, 12'h008, 0); chk(rd, 0);
    apb(1, 12'h000, 32'hA500_0001);
    chk({fault_proc_reset, fault_all_reset, wdt_irq}, 3'b101);
    apb(0, 12'h008, 0); chk(rd, 2); chk({wdt_irq, wdt_fault}, 0);
    apb(1, 12'h00C, 0);
    apb(1, 12'h000, 32'hA500_0001); chk({wdt_irq, wdt_fault}, 2'b01);
    apb(0, 12'h008, 0); chk(rd, 2);
    apb(1, 12'h00C, 3);
    apb(1, 12'h010, 3);
    debug_state <= 1; idle_state <= 1;
    repeat (256) @(posedge pclk);
    debug_state <= 0;
    // Idle stays high: idle halt is clear here, so counting must go on
    irq_after(5 * 128 - 40);
    idle_state <= 0;
    apb(0, 12'h008, 0); chk(rd, 1);
    repeat (300) @(posedge pclk);
    apb(1, 12'h000, 32'hA500_0001);
    apb(0, 12'h008, 0); chk(rd, 0);
    irq_after(5 * 128 - 3);
    apb(0, 12'h008, 0); chk(rd, 1);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({wdt_irq, wdt_fault}, 0);
    apb(1, 12'h004, 32'h0000_B004);
    apb(1, 12'h000, 32'hA500_0001); chk({fault_all_reset, fault_proc_reset}, 2'b10);
    apb(0, 12'h008, 0); chk(rd, 2);
    repeat (800) @(posedge pclk);
    apb(0, 12'h008, 0); chk(rd, 0);
    chk(word_type'(n_proc), 4); chk(word_type'(n_all), 1);
    report_and_stop;
  end
endmodule // test_windowed_watchdog_timer

/* File: bench/wdt_props.sv */
// Purpose: port-level assertions for the watchdog
// Assumes: one clock, async low reset
// Notes: flags are unseen, so clears are tied to bus cycles
module wdt_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic wdt_irq, // Interrupt
  input wire logic wdt_fault, // Fault
  input wire logic fault_proc_reset, // Processor reset only
  input wire logic fault_all_reset // All resets
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_flags;
  assign rd_flags = psel && penable && !pwrite && paddr == 12'h008;
  a_proc_scope: assert property (fault_proc_reset |-> wdt_fault && !fault_all_reset) else $error("proc scope");
  a_all_scope: assert property (fault_all_reset |-> wdt_fault && !fault_proc_reset) else $error("all scope");
  a_fault_holds: assert property (wdt_fault && !rd_flags |=> wdt_fault) else $error("fault dropped");
  a_irq_holds: assert property (wdt_irq && !psel |=> wdt_irq) else $error("irq dropped");
  a_fault_clear: assert property ($fell(wdt_fault) |-> $past(rd_flags)) else $error("fault fell");
  a_irq_clear: assert property ($fell(wdt_irq) |-> $past(psel && penable)) else $error("irq fell");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h010 |-> pslverr) else $error("no err");
  a_ctrl_no_err: assert property (psel && penable && paddr == 12'h000 |-> !pslverr && pready) else $error("err");
endmodule // wdt_props
bind windowed_watchdog_timer wdt_props wdt_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .wdt_irq(wdt_irq),
  .wdt_fault(wdt_fault), .fault_proc_reset(fault_proc_reset), .fault_all_reset(fault_all_reset));

/* File: hw/pin_sync.sv */
// Purpose: three-stage synchroniser for asynchronous level inputs
// Assumes: input from outside pclk domain
// Notes: output changes only when stages two and three agree
module pin_sync (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic din, // Raw level
  output logic dout // Filtered level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        out_r <= s3_r;
      end
    end
  end
  assign dout = out_r;
endmodule // pin_sync

/* File: hw/slow_prescaler.sv */
// Purpose: divide-by-128 tick generator from the slow clock enable
// Assumes: slow_en is a one-cycle enable in the pclk domain
// Notes: restart forces a full period before the next tick
`include "wdt_defs.svh"
module slow_prescaler (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic slow_en, // Slow clock enable
  input wire logic run, // Counting allowed
  input wire logic restart, // Reset divider
  output logic tick // One pulse per 128 slow ticks
);
  logic [6:0] div_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 7'h00;
    end else if (restart) begin
      div_r <= 7'h00;
    end else if (run && slow_en) begin
      div_r <= div_r + 7'h01;
    end
  end
  assign tick = run && slow_en && (div_r == `WDT_PRESCALE);
endmodule // slow_prescaler

/* File: hw/wdt_defs.svh */
// Purpose: constants of the windowed watchdog: offsets, fields, reset values
// Assumes: APB with 32-bit data, byte addresses
// Notes: included by the prescaler and the watchdog top design file
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define WDT_OFS_CTRL 12'h000
`define WDT_OFS_CFG 12'h004
`define WDT_OFS_FLAGS 12'h008
`define WDT_OFS_IRQ_EN 12'h00C
`define WDT_OFS_IRQ_CLR 12'h010
`define WDT_KEY 8'hA5
`define WDT_KEY_HI 31
`define WDT_KEY_LO 24
`define WDT_RESTART_BIT 0
`define WDT_RELOAD_HI 11
`define WDT_RELOAD_LO 0
`define WDT_FIEN_BIT 12
`define WDT_RSTEN_BIT 13
`define WDT_PROC_BIT 14
`define WDT_DIS_BIT 15
`define WDT_DELTA_HI 27
`define WDT_DELTA_LO 16
`define WDT_DBG_BIT 28
`define WDT_IDLE_BIT 29
`define WDT_CFG_RESET 32'h3FFF_2FFF
`define WDT_CFG_MASK 32'h3FFF_FFFF
`define WDT_UNF_BIT 0
`define WDT_ERR_BIT 1
`define WDT_PRESCALE 7'h7F
`define WDT_ZERO12 12'h000
`define WDT_ONE12 12'h001
`define WDT_COUNT_RESET 12'hFFF
`define WDT_IRQ_EN_RESET 2'h3
`define WDT_FLAG_HI 1
`define WDT_FLAG_LO 0
`endif

/* File: hw/wdt_pkg.sv */
// Purpose: types shared by the watchdog files
// Assumes: nothing beyond the constants header
// Notes: only types live here
package wdt_pkg;
  typedef logic [31:0] word_type;
  typedef logic [11:0] count_type;
  typedef logic [1:0] flags_type;
endpackage

/* File: hw/windowed_watchdog_timer.sv */
// Purpose: windowed watchdog with key-protected restart and write-once configuration
// Assumes: APB slave, pclk 40 MHz, slow clock given as a one-cycle enable
// Notes: debug and idle are asynchronous levels and are synchronised here
// Summary of operation
// - Control writes without key 0xA5 in the top byte are ignored entirely.
// - Keyed restart with counter at or below window delta reloads counter.
// - Keyed restart with counter above window delta raises a window error.
// - Every reload loads the counter from configuration bits 11 to 0.
// - Fault interrupt enable bit 12 routes faults to the interrupt.
// - Reset enable bit 13 lets faults request a watchdog reset.
// - Bit 14 chooses all resets at 0, processor reset only at 1.
// - Debug halt bit 28 stops counting while processor is in debug.
// - Idle halt bit 29 stops counting while system is idle.
// - Disable bit 15 stops the watchdog timer.
// - Underflow flag, status bit 0, holds until the status read.
// - Window error flag, status bit 1, holds until the status read.
// - Only first configuration write after reset is taken; it reloads counter.
// - Counter decrements once per 128 slow clock ticks.
// - Successful restart also restarts the divide-by-128 prescaler.
// - Status read or reset clears flags, interrupt and fault output.
//
// The placing of the registers and register access over APB were left to the implementer.
`include "wdt_defs.svh"
module windowed_watchdog_timer (
  input wire logic pclk, // APB clock, 40 MHz
  input wire logic presetn, // Processor reset, async low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire wdt_pkg::word_type pwdata, // APB write data
  output wdt_pkg::word_type prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic slow_clk_en, // Slow clock enable pulse
  input wire logic debug_state, // Processor in debug, async
  input wire logic idle_state, // System idle, async
  output logic wdt_irq, // Level interrupt
  output logic wdt_fault, // Fault to reset controller
  output logic fault_proc_reset, // Fault asks processor reset only
  output logic fault_all_reset // Fault asks all resets
);
  import wdt_pkg::*;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction

  word_type cfg_r;
  logic cfg_locked_r;
  count_type count_r;
  flags_type flags_r;
  flags_type irq_en_r;
  logic fault_r;
  word_type prdata_r;
  logic dbg_s;
  logic idle_s;
  logic tick;
  logic wr_acc;
  logic rd_acc;
  logic ctrl_ok;
  logic restart_ok;
  logic window_err;
  logic cfg_wr;
  logic running;
  logic underflow;
  logic flags_rd;
  logic mapped;
  count_type reload_value;
  count_type window_delta;
  flags_type flag_set;

  logic [1:0] async_lvl;
  logic [1:0] sync_lvl;
  assign async_lvl = {idle_state, debug_state};

  // Debug and idle come from other domains, one filter each
  for (genvar i = 0; i < $bits(async_lvl); i++) begin : g_sync
    pin_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(async_lvl[i]),
      .dout(sync_lvl[i])
    );
  end
  assign dbg_s = sync_lvl[0];
  assign idle_s = sync_lvl[1];

  assign pready = 1'b1;
  assign mapped = addr_is(paddr, `WDT_OFS_CTRL) || addr_is(paddr, `WDT_OFS_CFG) ||
                  addr_is(paddr, `WDT_OFS_FLAGS) || addr_is(paddr, `WDT_OFS_IRQ_EN) ||
                  addr_is(paddr, `WDT_OFS_IRQ_CLR);
  // Unmapped addresses answer with an error and change nothing
  assign pslverr = psel && penable && !mapped;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  assign reload_value = cfg_r[`WDT_RELOAD_HI:`WDT_RELOAD_LO];
  assign window_delta = cfg_r[`WDT_DELTA_HI:`WDT_DELTA_LO];

  assign ctrl_ok = wr_acc && addr_is(paddr, `WDT_OFS_CTRL) &&
                   (pwdata[`WDT_KEY_HI:`WDT_KEY_LO] == `WDT_KEY) && pwdata[`WDT_RESTART_BIT];
  assign restart_ok = ctrl_ok && (count_r <= window_delta);
  // restart outside window, flagged even when disabled
  assign window_err = ctrl_ok && (count_r > window_delta);
  assign cfg_wr = wr_acc && addr_is(paddr, `WDT_OFS_CFG) && !cfg_locked_r;
  assign running = !cfg_r[`WDT_DIS_BIT] && !(cfg_r[`WDT_DBG_BIT] && dbg_s) &&
                   !(cfg_r[`WDT_IDLE_BIT] && idle_s);
  assign underflow = tick && (count_r == `WDT_ZERO12);
  assign flags_rd = rd_acc && addr_is(paddr, `WDT_OFS_FLAGS);

  slow_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .slow_en(slow_clk_en),
    .run(running),
    .restart(restart_ok || cfg_wr),
    .tick(tick)
  );

  // configuration register, locked after first write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `WDT_CFG_RESET;
      cfg_locked_r <= 1'b0;
    end else if (cfg_wr) begin
      cfg_r <= pwdata & `WDT_CFG_MASK;
      cfg_locked_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= `WDT_COUNT_RESET;
    end else if (cfg_wr) begin
      count_r <= pwdata[`WDT_RELOAD_HI:`WDT_RELOAD_LO];
    end else if (restart_ok) begin
      count_r <= reload_value;
    end else if (underflow) begin
      count_r <= reload_value;
    end else if (tick) begin
      count_r <= count_r - `WDT_ONE12;
    end
  end

  assign flag_set = {window_err, underflow};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 2'h0;
    end else if (flags_rd) begin
      flags_r <= flag_set;
    end else begin
      flags_r <= flags_r | flag_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
    end else if (|flag_set) begin
      fault_r <= cfg_r[`WDT_RSTEN_BIT];
    end else if (flags_rd) begin
      fault_r <= 1'b0;
    end
  end

  // Interrupt enable shares the flag layout; the clear location is accepted
  // but leaves the flags alone, since they must hold until a status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= `WDT_IRQ_EN_RESET;
    end else if (wr_acc && addr_is(paddr, `WDT_OFS_IRQ_EN)) begin
      irq_en_r <= pwdata[`WDT_FLAG_HI:`WDT_FLAG_LO];
    end
  end

  // Read data registered at the access edge; write-only locations read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (addr_is(paddr, `WDT_OFS_CFG)) begin
        prdata_r <= cfg_r;
      end else if (addr_is(paddr, `WDT_OFS_FLAGS)) begin
        prdata_r <= {30'h0000_0000, flags_r | flag_set};
      end else if (addr_is(paddr, `WDT_OFS_IRQ_EN)) begin
        prdata_r <= {30'h0000_0000, irq_en_r};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end
  assign prdata = prdata_r;

  // fault interrupt gated by enable bit 12
  assign wdt_irq = cfg_r[`WDT_FIEN_BIT] && |(flags_r & irq_en_r);
  assign wdt_fault = fault_r;
  assign fault_proc_reset = fault_r && cfg_r[`WDT_PROC_BIT];
  assign fault_all_reset = fault_r && !cfg_r[`WDT_PROC_BIT];
endmodule // windowed_watchdog_timer
